// file: core/sfb_pkg.sv
/*
  shared constants and carriers for the status flags and bank select block.
  assumes one 50 MHz clock and a core that drives operations on that clock.
*/
package sfb_pkg;
  // register indices; byte address is four times the index
  localparam logic [8:0] IDX_STATUS = 9'h003;
  localparam logic [8:0] IDX_LATCH  = 9'h00a;
  localparam int unsigned MIRROR_W  = 7;

  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [4:0] RST_LATCH  = 5'h00;
  localparam logic [1:0] RESP_OKAY  = 2'h0;

  localparam int unsigned BIT_IBS = 7;
  localparam int unsigned BIT_DBH = 6;
  localparam int unsigned BIT_DBL = 5;
  localparam int unsigned BIT_WDX = 4;
  localparam int unsigned BIT_SLP = 3;
  localparam int unsigned BIT_Z   = 2;
  localparam int unsigned BIT_NC  = 1;
  localparam int unsigned BIT_C   = 0;

  typedef enum logic [3:0] {
    NO_INSTR                = 4'h0,
    ADD_INSTR               = 4'h1,
    SUB_INSTR               = 4'h2,
    AND_INSTR               = 4'h3,
    IOR_INSTR               = 4'h4,
    XOR_INSTR               = 4'h5,
    CLEAR_FILE_INSTR        = 4'h6,
    ROTATE_LEFT_INSTR       = 4'h7,
    ROTATE_RIGHT_INSTR      = 4'h8,
    BIT_SET_INSTR           = 4'h9,
    BIT_CLEAR_INSTR         = 4'ha,
    NIBBLE_SWAP_INSTR       = 4'hb,
    MOVE_FROM_WORKING_INSTR = 4'hc,
    WATCHDOG_KICK_INSTR     = 4'hd,
    SLEEP_INSTR             = 4'he
  } sfb_op_kind_t;

  typedef struct packed {
    logic         valid;
    sfb_op_kind_t kind;
    logic         dest_status;
    logic [2:0]   bit_sel;
    logic [7:0]   file_val;
    logic [7:0]   work_val;
  } sfb_op_t;
endpackage

// file: core/sfb_status_bank.sv
/*
  status flags, bank select, pc upper holding latch and axi4-lite access.
  assumes the core presents one operation per clock on op_i, synchronous.
*/
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps

// Notes on behaviour
// - status as destination of a flag-setting op: flags come from the op
// - watchdog expiry and sleep entry flags ignore all writes
// - clear-file on status zeroes bits 7:5, sets result-null, rest kept
// - direct bank bits pick one of four 128-byte banks
// - indirect bank bit picks banks 2-3 when one, banks 0-1 when zero
// - sleep flag set by power-up and kick; cleared by sleep
// - result-null flag follows whether the result is zero on add, subtract, and, or, xor and clear-file
// - nibble carry reflects carry out of bit 3 on add and subtract
// - msb carry reflects carry out of bit 7 on add and subtract
// - subtract adds the two's complement, so carries mean no borrow
// - rotates load msb carry with the bit shifted out
// - holding latch is copied into the pc upper bits on a pc load
// - status and holding latch decode the same in every bank
// - unimplemented locations read zero
module sfb_status_bank (
  input  wire  logic                 aclk,
  input  wire  logic                 aresetn,
  input  wire  logic [10:0]          s_axi_awaddr,
  input  wire  logic [2:0]           s_axi_awprot,
  input  wire  logic                 s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire  logic [31:0]          s_axi_wdata,
  input  wire  logic [3:0]           s_axi_wstrb,
  input  wire  logic                 s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire  logic                 s_axi_bready,
  input  wire  logic [10:0]          s_axi_araddr,
  input  wire  logic [2:0]           s_axi_arprot,
  input  wire  logic                 s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire  logic                 s_axi_rready,
  input  wire  sfb_pkg::sfb_op_t     op_i,
  input  wire  logic                 wdt_timeout,
  input  wire  logic                 other_reset,
  input  wire  logic                 pc_load,
  input  wire  logic [7:0]           pc_low,
  input  wire  logic [6:0]           direct_offset,
  input  wire  logic [7:0]           indirect_ptr,
  output logic [7:0]                 status_o,
  output logic [7:0]                 result_o,
  output logic [8:0]                 direct_addr_o,
  output logic [8:0]                 indirect_addr_o,
  output logic [12:0]                pc_o
);
  import sfb_pkg::*;

  logic [7:0]  status_q, status_d, result_q, result_d;
  logic [4:0]  latch_q;
  logic [12:0] pc_q;
  logic [8:0]  dir_q, ind_q;
  logic        awready_q, wready_q, aw_held_q, w_held_q, bvalid_q;
  logic        arready_q, rvalid_q;
  logic [8:0]  awidx_q;
  logic [7:0]  wbyte_q;
  logic        wlane_q;
  logic [31:0] rdata_q;
  logic        aw_fire, w_fire, b_fire, ar_fire, r_fire, wr_go;
  logic        wr_status, wr_latch;
  logic [7:0]  wr_merged, src_a, res;
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic        aff_z, aff_c, aff_nc, puts_res;

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data may arrive in either order

  assign aw_fire = s_axi_awvalid & awready_q;
  assign w_fire  = s_axi_wvalid & wready_q;
  assign b_fire  = bvalid_q & s_axi_bready;
  assign wr_go   = aw_held_q & w_held_q & ~bvalid_q;
  // only the low byte lane carries data; upper bits of each word read zero
  assign wr_status = wr_go & wlane_q & (awidx_q[MIRROR_W-1:0] == IDX_STATUS[MIRROR_W-1:0]);
  assign wr_latch  = wr_go & wlane_q & (awidx_q[MIRROR_W-1:0] == IDX_LATCH[MIRROR_W-1:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_held_q <= 1'b0;
      awidx_q   <= 9'h000;
    end else if (aw_fire) begin
      awready_q <= 1'b0;
      aw_held_q <= 1'b1;
      awidx_q   <= s_axi_awaddr[10:2];
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end else if (b_fire) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      w_held_q <= 1'b0;
      wbyte_q  <= 8'h00;
      wlane_q  <= 1'b0;
    end else if (w_fire) begin
      wready_q <= 1'b0;
      w_held_q <= 1'b1;
      wbyte_q  <= s_axi_wdata[7:0];
      wlane_q  <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end else if (b_fire) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
    end else if (b_fire) begin
      bvalid_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite read path; bank bits of the index are ignored for mirrors

  assign ar_fire = s_axi_arvalid & arready_q;
  assign r_fire  = rvalid_q & s_axi_rready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      unique case (s_axi_araddr[MIRROR_W+1:2])
        IDX_STATUS[MIRROR_W-1:0]: rdata_q <= {24'h00_0000, status_q};
        IDX_LATCH[MIRROR_W-1:0]:  rdata_q <= {27'h000_0000, latch_q};
        default:                  rdata_q <= 32'h0000_0000;
      endcase
    end else if (r_fire) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // operation datapath and status update

  always_comb begin
    wr_merged = status_q;
    if (wr_status) begin
      wr_merged[7:5] = wbyte_q[7:5];
      wr_merged[2:0] = wbyte_q[2:0];
    end
    // a status destination reads the value that includes a same-cycle bus write
    src_a = op_i.dest_status ? wr_merged : op_i.file_val;
    sum9  = 9'h000;
    sum5  = 5'h00;
    res   = src_a;
    aff_z = 1'b0;
    aff_c = 1'b0;
    aff_nc = 1'b0;
    puts_res = op_i.valid;
    unique case (op_i.kind)
      ADD_INSTR: begin
        sum9 = {1'b0, src_a} + {1'b0, op_i.work_val};
        sum5 = {1'b0, src_a[3:0]} + {1'b0, op_i.work_val[3:0]};
        res = sum9[7:0];
        {aff_z, aff_nc, aff_c} = 3'h7;
      end
      SUB_INSTR: begin
        sum9 = {1'b0, src_a} + {1'b0, ~op_i.work_val} + 9'h001;
        sum5 = {1'b0, src_a[3:0]} + {1'b0, ~op_i.work_val[3:0]} + 5'h01;
        res = sum9[7:0];
        {aff_z, aff_nc, aff_c} = 3'h7;
      end
      AND_INSTR: begin
        res = src_a & op_i.work_val;
        aff_z = 1'b1;
      end
      IOR_INSTR: begin
        res = src_a | op_i.work_val;
        aff_z = 1'b1;
      end
      XOR_INSTR: begin
        res = src_a ^ op_i.work_val;
        aff_z = 1'b1;
      end
      CLEAR_FILE_INSTR: begin
        res = 8'h00;
        aff_z = 1'b1;
      end
      ROTATE_LEFT_INSTR: begin
        res = {src_a[6:0], wr_merged[BIT_C]};
        sum9[8] = src_a[7];
        aff_c = 1'b1;
      end
      ROTATE_RIGHT_INSTR: begin
        res = {wr_merged[BIT_C], src_a[7:1]};
        sum9[8] = src_a[0];
        aff_c = 1'b1;
      end
      BIT_SET_INSTR:           res[op_i.bit_sel] = 1'b1;
      BIT_CLEAR_INSTR:         res[op_i.bit_sel] = 1'b0;
      NIBBLE_SWAP_INSTR:       res = {src_a[3:0], src_a[7:4]};
      MOVE_FROM_WORKING_INSTR: res = op_i.work_val;
      default:                 puts_res = 1'b0;
    endcase

    status_d = wr_merged;
    if (puts_res && op_i.dest_status) begin
      status_d[7:5] = res[7:5];
      // any flag-setting op locks all three flags against the written value
      if (!(aff_z | aff_nc | aff_c)) status_d[2:0] = res[2:0];
    end
    if (op_i.valid && aff_z) status_d[BIT_Z] = (res == 8'h00);
    if (op_i.valid && aff_nc) status_d[BIT_NC] = sum5[4];
    if (op_i.valid && aff_c) status_d[BIT_C] = sum9[8];
    if (wdt_timeout) status_d[BIT_WDX] = 1'b0;
    // a kick or sleep in the same cycle as a time-out wins the set
    if (op_i.valid && op_i.kind == WATCHDOG_KICK_INSTR) begin
      status_d[BIT_WDX] = 1'b1;
      status_d[BIT_SLP] = 1'b1;
    end
    if (op_i.valid && op_i.kind == SLEEP_INSTR) begin
      status_d[BIT_WDX] = 1'b1;
      status_d[BIT_SLP] = 1'b0;
    end
    if (other_reset) status_d[7:5] = 3'h0;
    result_d = puts_res ? res : result_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= RST_STATUS;
      result_q <= 8'h00;
    end else begin
      status_q <= status_d;
      result_q <= result_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bank addressing and pc upper latch

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= 9'h000;
      ind_q <= 9'h000;
    end else begin
      dir_q <= {status_q[BIT_DBH], status_q[BIT_DBL], direct_offset};
      ind_q <= {status_q[BIT_IBS], indirect_ptr};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q <= RST_LATCH;
    end else if (wr_latch) begin
      latch_q <= wbyte_q[4:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= 13'h0000;
    end else if (pc_load) begin
      pc_q <= {latch_q, pc_low};
    end
  end

  assign s_axi_awready   = awready_q;
  assign s_axi_wready    = wready_q;
  assign s_axi_bvalid    = bvalid_q;
  assign s_axi_bresp     = RESP_OKAY;
  assign s_axi_arready   = arready_q;
  assign s_axi_rvalid    = rvalid_q;
  assign s_axi_rdata     = rdata_q;
  assign s_axi_rresp     = RESP_OKAY;
  assign status_o        = status_q;
  assign result_o        = result_q;
  assign direct_addr_o   = dir_q;
  assign indirect_addr_o = ind_q;
  assign pc_o            = pc_q;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic quiet;
  assign quiet = ~wdt_timeout & ~other_reset & ~wr_status;

  sequence s_rd_take(logic [6:0] idx);
    ar_fire && s_axi_araddr[MIRROR_W+1:2] == idx;
  endsequence

  a_flags_ro_hold: assert property (
    wr_status && !op_i.valid && !wdt_timeout
    |=> status_q[4:3] == $past(status_q[4:3]))
    else $error("write changed read-only flags");
  a_clear_file_st: assert property (
    op_i.valid && op_i.kind == CLEAR_FILE_INSTR && op_i.dest_status && quiet
    |=> status_q[7:5] == 3'h0 && status_q[BIT_Z]
        && status_q[4:3] == $past(status_q[4:3])
        && status_q[1:0] == $past(status_q[1:0]))
    else $error("clear-file on status wrong");
  // the edge that sampled reset low loaded zeros, so only a running edge is checked
  a_direct_bank: assert property (
    aresetn |=> dir_q == {$past(status_q[6:5]), $past(direct_offset)})
    else $error("direct bank address wrong");
  a_indirect_bank: assert property (
    aresetn |=> ind_q == {$past(status_q[BIT_IBS]), $past(indirect_ptr)})
    else $error("indirect bank address wrong");
  a_kick_sets_flags: assert property (
    op_i.valid && op_i.kind == WATCHDOG_KICK_INSTR |=> status_q[4:3] == 2'h3)
    else $error("kick did not set flags");
  a_sleep_flags: assert property (
    op_i.valid && op_i.kind == SLEEP_INSTR |=> status_q[4:3] == 2'h2)
    else $error("sleep flags wrong");
  a_timeout_clear: assert property (
    wdt_timeout && !(op_i.valid && op_i.kind inside {WATCHDOG_KICK_INSTR, SLEEP_INSTR})
    |=> !status_q[BIT_WDX])
    else $error("time-out did not clear expiry flag");
  a_zero_tracks: assert property (
    op_i.valid && op_i.kind inside {ADD_INSTR, SUB_INSTR, AND_INSTR, XOR_INSTR}
    |=> status_q[BIT_Z] == (result_q == 8'h00))
    else $error("result-null flag wrong");
  a_add_carries: assert property (
    op_i.valid && op_i.kind == ADD_INSTR
    |=> status_q[BIT_C] == ({1'b0, $past(src_a)} + {1'b0, $past(op_i.work_val)} > 9'h0ff)
        && status_q[BIT_NC] == ($past(src_a[3:0]) + $past(op_i.work_val[3:0]) > 5'h0f))
    else $error("add carries wrong");
  a_sub_no_borrow: assert property (
    op_i.valid && op_i.kind == SUB_INSTR
    |=> status_q[BIT_C] == ($past(src_a) >= $past(op_i.work_val)))
    else $error("subtract borrow polarity wrong");
  a_rotate_carry: assert property (
    op_i.valid && op_i.kind == ROTATE_LEFT_INSTR |=> status_q[BIT_C] == $past(src_a[7]))
    else $error("rotate carry wrong");
  a_pc_upper_load: assert property (
    pc_load |=> pc_q == {$past(latch_q), $past(pc_low)})
    else $error("pc upper not taken from latch");
  a_mirror_read: assert property (
    s_rd_take(IDX_STATUS[MIRROR_W-1:0]) |=> rvalid_q && rdata_q == {24'h00_0000, $past(status_q)})
    else $error("mirrored status read wrong");
  a_latch_read: assert property (
    s_rd_take(IDX_LATCH[MIRROR_W-1:0]) |=> rvalid_q && rdata_q == {27'h000_0000, $past(latch_q)})
    else $error("mirrored latch read wrong");
  a_unmapped_zero: assert property (
    ar_fire && !(s_axi_araddr[MIRROR_W+1:2] inside {7'h03, 7'h0a}) |=> rdata_q == 32'h0)
    else $error("unimplemented location not zero");

endmodule // sfb_status_bank

// file: verif/tb_sfb_status_bank.sv
/*
  self-checking bench for the status flags and bank select block.
  assumes sfb_pkg is compiled first; one 50 MHz clock, registers over axi4-lite.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_sfb_status_bank;
  import sfb_pkg::*;

  typedef struct packed {
    sfb_op_kind_t k;
    logic [2:0]   b;
    logic [7:0]   f;
    logic [7:0]   w;
    logic [7:0]   st;
    logic [7:0]   res;
  } sfb_row_t;

  logic        aclk, aresetn;
  logic [10:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  sfb_op_t     op_i;
  logic        wdt_timeout, other_reset, pc_load;
  logic [7:0]  pc_low, indirect_ptr, status_o, result_o;
  logic [6:0]  direct_offset;
  logic [8:0]  direct_addr_o, indirect_addr_o;
  logic [12:0] pc_o;
  int          n_fail = 0;
  int          checked = 0;
  int          cyc = 0;

  // rows run in order: each expectation builds on the flags left by the row before
  sfb_row_t rows [18] = '{
    '{ADD_INSTR,               3'h0, 8'h0f, 8'h01, 8'h1a, 8'h10},
    '{ADD_INSTR,               3'h0, 8'hff, 8'h01, 8'h1f, 8'h00},
    '{SUB_INSTR,               3'h0, 8'h05, 8'h05, 8'h1f, 8'h00},
    '{SUB_INSTR,               3'h0, 8'h03, 8'h05, 8'h18, 8'hfe},
    '{CLEAR_FILE_INSTR,        3'h0, 8'haa, 8'h00, 8'h1c, 8'h00},
    '{SUB_INSTR,               3'h0, 8'h10, 8'h01, 8'h19, 8'h0f},
    '{AND_INSTR,               3'h0, 8'hf0, 8'h0f, 8'h1d, 8'h00},
    '{IOR_INSTR,               3'h0, 8'ha0, 8'h05, 8'h19, 8'ha5},
    '{XOR_INSTR,               3'h0, 8'h5a, 8'h5a, 8'h1d, 8'h00},
    '{ROTATE_LEFT_INSTR,       3'h0, 8'h40, 8'h00, 8'h1c, 8'h81},
    '{ROTATE_RIGHT_INSTR,      3'h0, 8'h01, 8'h00, 8'h1d, 8'h00},
    '{ROTATE_RIGHT_INSTR,      3'h0, 8'h02, 8'h00, 8'h1c, 8'h81},
    '{BIT_SET_INSTR,           3'h3, 8'h00, 8'h00, 8'h1c, 8'h08},
    '{BIT_CLEAR_INSTR,         3'h0, 8'hff, 8'h00, 8'h1c, 8'hfe},
    '{NIBBLE_SWAP_INSTR,       3'h0, 8'ha5, 8'h00, 8'h1c, 8'h5a},
    '{MOVE_FROM_WORKING_INSTR, 3'h0, 8'h00, 8'h3c, 8'h1c, 8'h3c},
    '{SLEEP_INSTR,             3'h0, 8'h00, 8'h00, 8'h14, 8'h3c},
    '{WATCHDOG_KICK_INSTR,     3'h0, 8'h00, 8'h00, 8'h1c, 8'h3c}
  };

  sfb_status_bank DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .op_i, .wdt_timeout, .other_reset, .pc_load, .pc_low, .direct_offset,
    .indirect_ptr, .status_o, .result_o, .direct_addr_o, .indirect_addr_o, .pc_o
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // a hang in a handshake wait lands here rather than running forever
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [10:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (aw_ok && w_ok && s_axi_bvalid === 1'b1) begin
        `CHK(s_axi_bresp, RESP_OKAY)
        s_axi_bready <= 1'b0;
        break;
      end
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    #1;
  endtask

  task automatic axi_rd(input logic [10:0] a, output logic [31:0] d);
    logic ar_ok;
    ar_ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (ar_ok && s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        `CHK(s_axi_rresp, RESP_OKAY)
        s_axi_rready <= 1'b0;
        break;
      end
      if (!ar_ok && s_axi_arready === 1'b1) begin
        ar_ok = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
    #1;
  endtask

  task automatic do_op(input sfb_op_kind_t k, input logic ds, input logic [2:0] b,
                       input logic [7:0] f, input logic [7:0] w);
    @(posedge aclk);
    op_i <= {1'b1, k, ds, b, f, w};
    @(posedge aclk);
    op_i <= '0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    op_i = '0;
    {wdt_timeout, other_reset, pc_load} = '0;
    pc_low = 8'h34;
    direct_offset = 7'h55;
    indirect_ptr = 8'haa;
    repeat (5) @(posedge aclk);
    #1;
    `CHK(status_o, RST_STATUS)
    `CHK(pc_o, 13'h0000)
    @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      do_op(rows[i].k, 1'b0, rows[i].b, rows[i].f, rows[i].w);
      `CHK(result_o, rows[i].res)
      `CHK(status_o, rows[i].st)
    end
    for (int m = 0; m < 4; m++) begin
      axi_rd(11'(12'h00c + 12'h200 * m), rd);
      `CHK(rd, 32'h0000_001c)
    end
    do_op(SLEEP_INSTR, 1'b0, 3'h0, 8'h00, 8'h00);
    axi_wr(11'h00c, 32'h0000_00ff, 4'hf);
    `CHK(status_o, 8'hf7)
    axi_wr(11'h60c, 32'h0000_0000, 4'hf);
    `CHK(status_o, 8'h10)
    axi_wr(11'h00c, 32'h0000_0027, 4'hf);
    // written carry bit is 1 but the add sets it from the operation
    do_op(ADD_INSTR, 1'b1, 3'h0, 8'h00, 8'h0a);
    `CHK(result_o, 8'h41)
    `CHK(status_o, 8'h52)
    do_op(CLEAR_FILE_INSTR, 1'b1, 3'h0, 8'h00, 8'h00);
    `CHK(status_o, 8'h16)
    @(posedge aclk);
    wdt_timeout <= 1'b1;
    @(posedge aclk);
    wdt_timeout <= 1'b0;
    #1;
    `CHK(status_o, 8'h06)
    do_op(WATCHDOG_KICK_INSTR, 1'b0, 3'h0, 8'h00, 8'h00);
    `CHK(status_o, 8'h1e)
    axi_wr(11'h00c, 32'h0000_00e0, 4'hf);
    @(posedge aclk);
    other_reset <= 1'b1;
    @(posedge aclk);
    other_reset <= 1'b0;
    #1;
    `CHK(status_o, 8'h18)
    axi_wr(11'h00c, 32'h0000_00ff, 4'h0);
    `CHK(status_o, 8'h18)
    // flag-neutral ops aimed at status: bits 7:5 and 2:0 take the result, bits 4:3 hold
    do_op(BIT_SET_INSTR, 1'b1, 3'h5, 8'h00, 8'h00);
    `CHK(status_o, 8'h38)
    do_op(BIT_CLEAR_INSTR, 1'b1, 3'h3, 8'h00, 8'h00);
    `CHK(status_o, 8'h38)
    `CHK(result_o, 8'h30)
    do_op(MOVE_FROM_WORKING_INSTR, 1'b1, 3'h0, 8'h00, 8'he7);
    `CHK(status_o, 8'hff)
    for (int v = 0; v < 8; v++) begin
      axi_wr(11'h00c, {24'h0, v[2:0], 5'h00}, 4'hf);
      @(posedge aclk);
      #1;
      `CHK(status_o, {v[2:0], 5'h18})
      `CHK(direct_addr_o, {v[1:0], 7'h55})
      `CHK(indirect_addr_o, {v[2], 8'haa})
    end
    // bank 1 mirror of the holding latch, read back through bank 0
    axi_wr(11'h228, 32'hffff_fff5, 4'hf);
    axi_rd(11'h028, rd);
    `CHK(rd, 32'h0000_0015)
    `CHK(pc_o, 13'h0000)
    @(posedge aclk);
    pc_load <= 1'b1;
    @(posedge aclk);
    pc_load <= 1'b0;
    #1;
    `CHK(pc_o, 13'h1534)
    axi_wr(11'h010, 32'hffff_ffff, 4'hf);
    axi_rd(11'h010, rd);
    `CHK(rd, 32'h0000_0000)
    axi_rd(11'h7fc, rd);
    `CHK(rd, 32'h0000_0000)
    // reset again in mid-run: everything returns to its power-up value
    @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    `CHK(status_o, RST_STATUS)
    `CHK(pc_o, 13'h0000)
    axi_rd(11'h028, rd);
    `CHK(rd, {27'h0, RST_LATCH})
    tally_and_finish();
  end
endmodule // tb_sfb_status_bank
